// ### ris_pkg.sv
// package: register map, field positions and reset values of the irq/status unit
package ris_pkg;
  // register addresses on the internal register port
  localparam logic [7:0] ADDR_CAUSE = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h0d;
  localparam logic [7:0] ADDR_GAIN = 8'h0e;
  localparam logic [7:0] ADDR_RSSI = 8'h0f;
  // reset values
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h37;
  // bits of the mask that always read and act as set
  localparam logic [7:0] MASK_FIXED = 8'hc0;
  // cause bit positions
  localparam int BIT_TX = 7;
  localparam int BIT_RX = 6;
  localparam int BIT_FIFO = 5;
  localparam int BIT_CRC = 4;
  localparam int BIT_HDR = 3;
  localparam int BIT_SHORT = 2;
  localparam int BIT_PRE = 1;
  localparam int BIT_NORESP = 0;
  // fifo level thresholds in bytes
  localparam logic [4:0] FIFO_LOW = 5'h08;
  localparam logic [4:0] FIFO_HIGH = 5'h10;
  localparam logic [4:0] FIFO_TWO = 5'h02;
  // read port states
  typedef enum logic [1:0] {
    RIS_IDLE = 2'b00,
    RIS_READ = 2'b01
  } ris_rd_state_t;
endpackage

// ### ris_snap.sv
// snapshot register holding receive-side measurements between rx start and next tx
`timescale 1ns/1ps
`default_nettype none
module ris_snap #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic capture, // load new value
  input wire logic track, // follow input while a reception runs
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] val_r; // held value
  logic [W-1:0] val_nxt;
  // hold between receptions so software sees the last frame's figure
  always_comb begin
    val_nxt = val_r;
    if (capture || track) begin
      val_nxt = din;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      val_r <= '0;
    end else begin
      val_r <= val_nxt;
    end
  end
  assign dout = val_r;
endmodule
`default_nettype wire

// ### ris_irq_status.sv
// interrupt cause, mask, gain/internal status and signal strength registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] bit7 during tx, interrupt at tx end
// [RULE2] bit6 during rx, interrupt at rx end
// [RULE3] bit5 when fifo below 8 or above 16
// [RULE4] bit4 on crc failure, maskable
// [RULE5] bit3 header high, or two bytes alt
// [RULE6] bit2 on reception shorter than expected
// [RULE7] bit1 preamble error, or rx finished alt
// [RULE8] bit0 on no-response timeout
// [RULE9] cause cleared on reset or enable low
// [RULE10] cause clears after host read, drops irq
// [RULE11] mask bit3 enables header interrupt
// [RULE12] mask bit2 enables short reception interrupt
// [RULE13] mask bit1 enables preamble error interrupt
// [RULE14] mask bit0 enables no-response interrupt
// [RULE15] tx and rx sources always enabled
// [RULE16] mask loads 37h on reset/enable low
// [RULE17] gain level in bits 6..4
// [RULE18] bit3 channel select, valid rx to tx
// [RULE19] rssi: i low nibble, q high nibble
// [RULE20] rssi valid from rx start to tx
// [RULE21] irq high iff enabled cause bit set
module ris_irq_status #(
  parameter int FIFO_AW = 5 // fifo level width
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic chip_en, // enable pin, low presets registers
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr, // one-cycle write strobe
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd, // level, high for the whole read phase
  output logic [7:0] reg_rdata,
  // events from the datapath (one-cycle pulses unless noted)
  input wire logic tx_active, // level, transmission in progress
  input wire logic rx_active, // level, reception in progress
  input wire logic [FIFO_AW-1:0] fifo_level,
  input wire logic fifo_receiving, // level, fifo direction is receive
  input wire logic crc_fail_flag,
  input wire logic header_bit_high,
  input wire logic short_reception_flag,
  input wire logic preamble_fail_flag,
  input wire logic noresp_timeout,
  input wire logic alt_flag_select, // level, alternate bit3/bit1 meaning
  // analog status inputs
  input wire logic [2:0] agc_level,
  input wire logic channel_select,
  input wire logic carrier_level_stable,
  input wire logic pll_locked,
  input wire logic osc_stable,
  input wire logic [3:0] rssi_i,
  input wire logic [3:0] rssi_q,
  output logic irq
);
  logic [7:0] cause_r; // interrupt cause, cleared on read
  logic [7:0] cause_nxt;
  logic [7:0] mask_r; // writable mask bits
  logic [7:0] mask_nxt;
  logic tx_d_r; // delayed tx level for edges
  logic rx_d_r;
  logic fifo_d_r; // delayed threshold condition
  logic two_d_r;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  ris_pkg::ris_rd_state_t rd_state_r;
  ris_pkg::ris_rd_state_t rd_state_nxt;
  logic [7:0] events; // this cycle's set requests
  logic fifo_cond;
  logic two_cond;
  logic tx_start;
  logic rx_start;
  logic rd_cause_end;
  logic preset; // reset or enable low
  logic chan_q; // captured receive channel select
  logic [7:0] rssi_q8;
  logic [2:0] agc_q;

  assign preset = srst || !chip_en; // [RULE9] [RULE16]
  assign tx_start = tx_active && !tx_d_r;
  assign rx_start = rx_active && !rx_d_r;

  // threshold tests on the fifo fill level
  assign fifo_cond = fifo_receiving
    ? (fifo_level > FIFO_AW'(ris_pkg::FIFO_HIGH))
    : (fifo_level < FIFO_AW'(ris_pkg::FIFO_LOW)); // [RULE3]
  assign two_cond = fifo_level >= FIFO_AW'(ris_pkg::FIFO_TWO);

  // event collection; fifo level flags latch on entry to their condition, tx/rx levels on their end
  always_comb begin
    events = 8'h00;
    events[ris_pkg::BIT_TX] = tx_d_r && !tx_active; // [RULE1]
    events[ris_pkg::BIT_RX] = rx_d_r && !rx_active; // [RULE2]
    events[ris_pkg::BIT_FIFO] = fifo_cond && !fifo_d_r; // [RULE3]
    events[ris_pkg::BIT_CRC] = crc_fail_flag; // [RULE4]
    events[ris_pkg::BIT_HDR] = alt_flag_select
      ? (two_cond && !two_d_r) : header_bit_high; // [RULE5]
    events[ris_pkg::BIT_SHORT] = short_reception_flag; // [RULE6]
    events[ris_pkg::BIT_PRE] = alt_flag_select
      ? (rx_d_r && !rx_active) : preamble_fail_flag; // [RULE7]
    events[ris_pkg::BIT_NORESP] = noresp_timeout; // [RULE8]
  end

  // read phase tracker: clear fires when a cause read ends
  always_comb begin
    rd_state_nxt = rd_state_r;
    rd_cause_end = 1'b0;
    case (rd_state_r)
      ris_pkg::RIS_IDLE: begin
        if (reg_rd && reg_addr == ris_pkg::ADDR_CAUSE) begin
          rd_state_nxt = ris_pkg::RIS_READ;
        end
      end
      ris_pkg::RIS_READ: begin
        if (!reg_rd) begin
          rd_cause_end = 1'b1; // [RULE10]
          rd_state_nxt = ris_pkg::RIS_IDLE;
        end
      end
      default: begin
        rd_state_nxt = ris_pkg::RIS_IDLE;
      end
    endcase
  end

  // cause register: new events win over the read clear
  always_comb begin
    cause_nxt = cause_r;
    if (rd_cause_end) begin
      cause_nxt = 8'h00; // [RULE10]
    end
    cause_nxt = cause_nxt | events;
    // bit7 and bit6 also show tx/rx in progress
    cause_nxt[ris_pkg::BIT_TX] = cause_nxt[ris_pkg::BIT_TX] | tx_active; // [RULE1]
    cause_nxt[ris_pkg::BIT_RX] = cause_nxt[ris_pkg::BIT_RX] | rx_active; // [RULE2]
  end

  // mask register; top two bits are not writable
  always_comb begin
    mask_nxt = mask_r;
    if (reg_wr && reg_addr == ris_pkg::ADDR_MASK) begin
      mask_nxt = reg_wdata | ris_pkg::MASK_FIXED; // [RULE15]
    end
  end

  // read mux, registered so data comes from flops
  always_comb begin
    case (reg_addr)
      ris_pkg::ADDR_CAUSE: rdata_nxt = cause_r;
      // fixed bits forced here too, since the preset value leaves them clear
      ris_pkg::ADDR_MASK: rdata_nxt = mask_r | ris_pkg::MASK_FIXED; // [RULE15] [RULE16]
      ris_pkg::ADDR_GAIN: begin
        rdata_nxt = {1'b0, agc_q, chan_q, carrier_level_stable,
          pll_locked, osc_stable}; // [RULE17] [RULE18]
      end
      ris_pkg::ADDR_RSSI: rdata_nxt = rssi_q8; // [RULE19]
      default: rdata_nxt = 8'h00;
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (preset) begin
      cause_r <= ris_pkg::CAUSE_RST; // [RULE9]
      mask_r <= ris_pkg::MASK_RST; // [RULE16]
      tx_d_r <= 1'b0;
      rx_d_r <= 1'b0;
      fifo_d_r <= 1'b0;
      two_d_r <= 1'b0;
      rd_state_r <= ris_pkg::RIS_IDLE;
      rdata_r <= 8'h00;
    end else begin
      cause_r <= cause_nxt;
      mask_r <= mask_nxt;
      tx_d_r <= tx_active;
      rx_d_r <= rx_active;
      fifo_d_r <= fifo_cond;
      two_d_r <= two_cond;
      rd_state_r <= rd_state_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // irq: any cause bit whose mask bit (forced for 7/6) is set
  always_comb begin
    irq = |(cause_r & (mask_r | ris_pkg::MASK_FIXED)); // [RULE21] [RULE11] [RULE12] [RULE13] [RULE14] [RULE4] [RULE15]
  end

  // rssi and channel snapshots follow during rx, then hold until the next rx start; the agc snapshot loads every cycle
  ris_snap #(.W(8)) u_rssi (
    .clk(clk),
    .srst(preset),
    .capture(rx_start),
    .track(rx_active && !tx_start),
    .din({rssi_q, rssi_i}), // [RULE19] [RULE20]
    .dout(rssi_q8)
  );
  ris_snap #(.W(1)) u_chan (
    .clk(clk),
    .srst(preset),
    .capture(rx_start),
    .track(rx_active),
    .din(channel_select), // [RULE18]
    .dout(chan_q)
  );
  ris_snap #(.W(3)) u_agc (
    .clk(clk),
    .srst(preset),
    .capture(1'b1),
    .track(1'b0),
    .din(agc_level), // [RULE17]
    .dout(agc_q)
  );
endmodule
`default_nettype wire

// ### ris_assertions.sv
// port checker of the irq/status unit
`timescale 1ns/1ps
`default_nettype none
module ris_assertions #(
  parameter int FIFO_AW = 5
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic chip_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic [FIFO_AW-1:0] fifo_level,
  input wire logic crc_fail_flag,
  input wire logic header_bit_high,
  input wire logic short_reception_flag,
  input wire logic preamble_fail_flag,
  input wire logic noresp_timeout,
  input wire logic alt_flag_select,
  input wire logic [2:0] agc_level,
  input wire logic [3:0] rssi_i,
  input wire logic [3:0] rssi_q,
  input wire logic irq
);
  logic [7:0] mask_r; // shadow of the mask register
  logic [7:0] mask_nxt;
  logic [7:0] en; // mask that acts at this edge, none while a write lands
  logic quiet; // no event input active
  // shadow follows writes; fixed bits always read as set
  always_comb begin
    mask_nxt = mask_r;
    if (reg_wr && reg_addr == ris_pkg::ADDR_MASK) begin
      mask_nxt = reg_wdata | ris_pkg::MASK_FIXED;
    end
    if (srst || !chip_en) begin
      mask_nxt = ris_pkg::MASK_RST | ris_pkg::MASK_FIXED;
    end
  end
  always_ff @(posedge clk) begin
    mask_r <= mask_nxt;
  end
  assign en = reg_wr ? 8'h00 : mask_r & {8{chip_en}};
  assign quiet = !(tx_active | rx_active | crc_fail_flag | header_bit_high
    | short_reception_flag | preamble_fail_flag | noresp_timeout);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // whole read phase of the cause register with nothing new arriving
  sequence s_read;
    reg_rd && reg_addr == ris_pkg::ADDR_CAUSE && quiet && $stable(fifo_level)
    ##1 !reg_rd && quiet && chip_en && $stable(fifo_level);
  endsequence
  property p_ev(logic e, logic m);
    e && m && !alt_flag_select |=> irq;
  endproperty
  a_tx_irq: assert property (tx_active && chip_en |=> irq)
    else $error("tx flag missing");
  a_rx_irq: assert property (rx_active && chip_en |=> irq)
    else $error("rx flag missing");
  a_crc_irq: assert property (p_ev(crc_fail_flag, en[4]))
    else $error("crc irq missing");
  a_hdr_irq: assert property (p_ev(header_bit_high, en[3]))
    else $error("header irq missing");
  a_short_irq: assert property (p_ev(short_reception_flag, en[2]))
    else $error("short irq missing");
  a_pre_irq: assert property (p_ev(preamble_fail_flag, en[1]))
    else $error("preamble irq missing");
  a_noresp_irq: assert property (p_ev(noresp_timeout, en[0]))
    else $error("noresp irq missing");
  a_read_clears: assert property (s_read |=> !irq)
    else $error("irq kept after read");
  a_enable_low: assert property (!chip_en |=> !irq && reg_rdata == 8'h00)
    else $error("enable low not clearing");
  a_mask_read: assert property (chip_en && reg_addr == ris_pkg::ADDR_MASK
    |=> reg_rdata == $past(mask_r)) else $error("mask readback wrong");
  a_gain_live: assert property (chip_en && $past(chip_en) && !$past(srst)
    && reg_addr == ris_pkg::ADDR_GAIN |=> reg_rdata[7:4] == {1'h0, $past(agc_level, 2)})
    else $error("gain field wrong");
  a_rssi_pair: assert property ((chip_en && rx_active && $stable({rssi_q, rssi_i}))[*3]
    ##0 reg_addr == ris_pkg::ADDR_RSSI |=> reg_rdata == {$past(rssi_q), $past(rssi_i)})
    else $error("rssi nibbles wrong");
endmodule
bind ris_irq_status ris_assertions #(.FIFO_AW(FIFO_AW)) u_chk (.*);
`default_nettype wire

// ### ris_host.sv
// host model: register reads and writes on the internal port
`timescale 1ns/1ps
`default_nettype none
module ris_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  // idle address is unmapped, so nothing is selected between accesses
  initial begin
    reg_addr = 8'hff;
    reg_wr = 1'h0;
    reg_wdata = 8'h00;
    reg_rd = 1'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge clk);
    #1;
    reg_wr = 1'h0;
    reg_addr = 8'hff;
    reg_wdata = ~d; // stale data must not look valid
  endtask
  // read phase ends one edge after the address; data taken at that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'h1;
    @(posedge clk);
    #1;
    d = reg_rdata;
    reg_rd = 1'h0;
    reg_addr = 8'hff;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench of the irq/status unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, srst = 1, chip_en = 1, tx = 0, rx = 0, rcv = 0, alt = 0, chan = 0;
  logic wr, rd, irq;
  logic [4:0] ev = 0, lvl = 5'h0c; // events: crc, header, short, preamble, noresp
  logic [2:0] agc = 0, ok = 3'h7;
  logic [7:0] q = 0, d, addr, wdata, rdata;
  int mismatches = 0, compares = 0;
  ris_irq_status DUT (.clk(clk), .srst(srst), .chip_en(chip_en), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .tx_active(tx), .rx_active(rx),
    .fifo_level(lvl), .fifo_receiving(rcv), .crc_fail_flag(ev[4]), .header_bit_high(ev[3]),
    .short_reception_flag(ev[2]), .preamble_fail_flag(ev[1]), .noresp_timeout(ev[0]),
    .alt_flag_select(alt), .agc_level(agc), .channel_select(chan), .carrier_level_stable(ok[2]),
    .pll_locked(ok[1]), .osc_stable(ok[0]), .rssi_i(q[3:0]), .rssi_q(q[7:4]), .irq(irq));
  ris_host host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
    .reg_rd(rd));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // read, compare, then let the clearing edge pass
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(d, e);
    step(1);
  endtask
  task automatic pulse(input logic [4:0] e);
    ev = e;
    step(1);
    ev = 0;
  endtask
  task automatic t_txrx;
    tx = 1;
    step(3);
    chk({7'h00, irq}, 8'h01);
    tx = 0;
    rdc(8'h0c, 8'h80);
    chk({7'h00, irq}, 8'h00);
    rx = 1;
    step(3);
    rx = 0;
    rdc(8'h0c, 8'h40);
    $display("txrx done");
  endtask
  task automatic t_events;
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i);
      chk({7'h00, ris_pkg::MASK_RST[i]}, {7'h00, irq});
      rdc(8'h0c, 8'h01 << i);
    end
    host.wr(8'h0d, 8'h08);
    pulse(5'h08);
    chk({7'h00, irq}, 8'h01);
    rdc(8'h0c, 8'h08);
    host.wr(8'h0d, 8'h00);
    pulse(5'h11);
    chk({7'h00, irq}, 8'h00);
    rdc(8'h0d, 8'hc0);
    rdc(8'h0c, 8'h11);
    $display("events done");
  endtask
  task automatic t_fifo;
    host.wr(8'h0d, 8'h20);
    lvl = 5'h07;
    step(2);
    chk({7'h00, irq}, 8'h01);
    rdc(8'h0c, 8'h20);
    lvl = 5'h10;
    rcv = 1;
    step(2);
    rdc(8'h0c, 8'h00);
    lvl = 5'h11;
    step(2);
    rdc(8'h0c, 8'h20);
    lvl = 5'h00;
    alt = 1;
    step(1);
    lvl = 5'h02;
    rx = 1;
    step(2);
    rx = 0;
    rdc(8'h0c, 8'h4a);
    alt = 0;
    $display("fifo done");
  endtask
  task automatic t_status;
    agc = 3'h5;
    chan = 1;
    ok = 3'h5;
    q = 8'ha3;
    rx = 1;
    step(3);
    rdc(8'h0e, 8'h5d);
    rdc(8'h0f, 8'ha3);
    rx = 0;
    step(1);
    q = 8'h5c;
    chan = 0;
    agc = 3'h2;
    step(2);
    rdc(8'h0f, 8'ha3);
    rdc(8'h0e, 8'h2d);
    rdc(8'h0c, 8'h40);
    rdc(8'h20, 8'h00);
    $display("status done");
  endtask
  task automatic t_enable;
    host.wr(8'h0d, 8'h01);
    pulse(5'h01);
    chk({7'h00, irq}, 8'h01);
    chip_en = 0;
    step(2);
    chk({7'h00, irq}, 8'h00);
    chip_en = 1;
    rdc(8'h0d, 8'hf7);
    rdc(8'h0c, 8'h00);
    $display("enable done");
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    step(8);
    srst = 0;
    rdc(8'h0d, 8'hf7);
    rdc(8'h0c, 8'h00);
    t_txrx;
    t_events;
    t_fifo;
    t_status;
    t_enable;
    conclude;
  end
  // the whole run needs about 120 cycles
  initial begin
    #100000;
    mismatches++;
    conclude;
  end
endmodule
`default_nettype wire
